// [common/srfe_pkg.sv]
// Package of constants and bus carriers for the servo reference front end
package srfe_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RESTART = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CLAMP_LEVEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MATCH_WINDOW = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ASSIGN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_POS_CMD = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CLAMP_POS = 8'h1C;
  // Field positions of the mode register
  localparam int unsigned MODE_SEL_LSB = 0;
  localparam int unsigned MODE_FORM_LSB = 4;
  localparam int unsigned MODE_INV_LSB = 8;
  // Field positions of the assignment register
  localparam int unsigned ASG_IN_A_LSB = 0;
  localparam int unsigned ASG_IN_B_LSB = 4;
  localparam int unsigned ASG_OUT_LSB = 8;
  // Control mode codes
  localparam logic [3:0] CTRL_SPEED = 4'h0;
  localparam logic [3:0] CTRL_POSITION = 4'h1;
  localparam logic [3:0] CTRL_SPEED_CLAMP = 4'hA;
  // Pulse input form codes
  localparam logic [2:0] FORM_STEP_DIR = 3'h0;
  localparam logic [2:0] FORM_FWD_REV = 3'h1;
  localparam logic [2:0] FORM_QUAD_X1 = 3'h2;
  localparam logic [2:0] FORM_QUAD_X2 = 3'h3;
  localparam logic [2:0] FORM_QUAD_X4 = 3'h4;
  // Reset values and limits, speeds in rpm
  localparam logic [3:0] RST_MODE_SEL = 4'h0;
  localparam logic [2:0] RST_FORM = 3'h0;
  localparam logic [1:0] RST_INV = 2'h0;
  localparam logic [15:0] RST_CLAMP_LEVEL = 16'h000A;
  localparam logic [15:0] MAX_CLAMP_LEVEL = 16'h0BB8;
  localparam logic [15:0] RST_MATCH_WINDOW = 16'h000A;
  localparam logic [15:0] MAX_MATCH_WINDOW = 16'h0064;
  localparam logic [3:0] ASG_NONE = 4'hF;
  localparam logic [3:0] RST_OUT_ASSIGN = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // AXI4-Lite master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } srfe_axil_req_type;

  // AXI4-Lite slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srfe_axil_rsp_type;
endpackage : srfe_pkg

// [design/srfe_top.sv]
// Servo reference front end: zero clamp, speed match and pulse-train decoder
//
// Overview of operation
// - Clamp request low, reference below level: hold position, ignore reference.
// - Clamp level 0 to 3000 rpm, reset 10, acts at once.
// - While clamped, show error to captured position so the loop returns there.
// - Mode A clamps only with proportional input low and reference below level.
// - Clamp request unmapped after reset until an input assignment maps it.
// - Speed match low when speed error below window, else high.
// - Match window 0 to 100 rpm, reset 10, acts at once.
// - Speed match only in speed control; position control shows positioning complete.
// - Output assignment routes speed match to any output terminal.
// - Mode 1 at restart: position control from pulse-train inputs.
// - Form 0 step/direction, 1 forward/reverse, 2..4 quadrature x1, x2, x4.
// - Multiplication only in quadrature; other forms count one per pulse.
// - Inversion 0 none, 1 direction, 2 step, 3 both; acts after restart.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module srfe_top #(
  parameter int unsigned IN_TERMS = 8,   // Number of input terminals
  parameter int unsigned OUT_TERMS = 4,  // Number of output terminals
  parameter int unsigned PCON_TERM = 2   // Fixed terminal of the proportional input
) (
  input wire logic clk_i,                              // 10 MHz clock
  input wire logic resetn_i,                           // Async reset, active low
  input wire srfe_pkg::srfe_axil_req_type axil_req_i,  // Register bus request
  output srfe_pkg::srfe_axil_rsp_type axil_rsp_o,      // Register bus response
  input wire logic ref_pin_a_i,                        // Step, forward pulse or phase A pin
  input wire logic ref_pin_b_i,                        // Direction, reverse pulse or phase B pin
  input wire logic [IN_TERMS-1:0] term_in_i,           // Input terminals, active low
  output logic [OUT_TERMS-1:0] term_out_o,             // Output terminals, active low
  input wire logic signed [15:0] speed_ref_i,          // Converted speed reference, rpm
  input wire logic signed [15:0] motor_speed_i,        // Actual motor speed, rpm
  input wire logic signed [31:0] feedback_pos_i,       // Encoder position, pulses
  input wire logic position_done_i,                    // Positioning complete
  output logic signed [15:0] speed_cmd_o,              // Speed command, zero while clamped
  output logic clamp_active_o,                         // Zero clamp engaged
  output logic signed [31:0] clamp_error_o,            // Clamp position minus feedback
  output logic clamp_in_band_o,                        // Within one pulse of clamp position
  output logic position_mode_o,                        // Position control active
  output logic signed [31:0] pos_cmd_o                 // Pulse-train position command
);
  import srfe_pkg::*;

  localparam int unsigned NP = IN_TERMS + 2;

  typedef enum logic {CLAMP_FREE, CLAMP_HOLD} srfe_clamp_type;

  // Settings written by software, and those in force since the last restart
  logic [3:0] mode_sel_r, asg_in_a_r, asg_in_b_r, asg_out_r, mode_eff_r;
  logic [2:0] form_r, form_eff_r;
  logic [1:0] inv_r, inv_eff_r;
  logic [15:0] clamp_level_r, match_window_r;
  logic restart_r;
  // Bus state
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r, wr_fire;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  // Pin conditioning
  logic [NP-1:0] pin_raw, sync1_r, sync2_r, sync3_r, pin_filt_r;
  // Decoder
  logic ch_a, ch_b, ch_a_prev_r, ch_b_prev_r;
  logic signed [1:0] pos_delta;
  logic signed [31:0] pos_cmd_r;
  // Clamp and match
  srfe_clamp_type clamp_state_r;
  logic signed [31:0] clamp_pos_r, clamp_err;
  logic [16:0] ref_abs;
  logic [17:0] spd_diff_abs;
  logic signed [17:0] spd_diff;
  logic clamp_req, pcon_on, clamp_cond, speed_match_r, positioning_complete_output_r;

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Mapped offsets; others answer SLVERR
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a inside {OFS_MODE, OFS_RESTART, OFS_CLAMP_LEVEL, OFS_MATCH_WINDOW, OFS_ASSIGN, OFS_STATUS,
                     OFS_POS_CMD, OFS_CLAMP_POS};
  endfunction : mapped

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (axil_req_i.awvalid && axil_rsp_o.awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= axil_req_i.awaddr;
      end
      if (axil_req_i.wvalid && axil_rsp_o.wready) begin
        w_got_r <= 1'b1;
        wdata_r <= axil_req_i.wdata;
        wstrb_r <= axil_req_i.wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

  // Write response, one cycle after both halves are held
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (axil_req_i.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Software settings; out-of-range speeds keep the old value
  always_ff @(posedge clk_i or negedge resetn_i) begin
    logic [31:0] v;
    if (!resetn_i) begin
      mode_sel_r <= RST_MODE_SEL;
      form_r <= RST_FORM;
      inv_r <= RST_INV;
      clamp_level_r <= RST_CLAMP_LEVEL;
      match_window_r <= RST_MATCH_WINDOW;
      asg_in_a_r <= ASG_NONE;
      asg_in_b_r <= ASG_NONE;
      asg_out_r <= RST_OUT_ASSIGN;
    end else if (wr_fire) begin
      case (awaddr_r)
        OFS_MODE: begin
          v = merge({22'h0, inv_r, 1'b0, form_r, mode_sel_r}, wdata_r, wstrb_r);
          mode_sel_r <= v[MODE_SEL_LSB +: 4];
          form_r <= v[MODE_FORM_LSB +: 3];
          inv_r <= v[MODE_INV_LSB +: 2];
        end
        OFS_CLAMP_LEVEL: begin
          v = merge({16'h0, clamp_level_r}, wdata_r, wstrb_r);
          if (v[31:16] == 16'h0000 && v[15:0] <= MAX_CLAMP_LEVEL) begin
            clamp_level_r <= v[15:0];
          end
        end
        OFS_MATCH_WINDOW: begin
          v = merge({16'h0, match_window_r}, wdata_r, wstrb_r);
          if (v[31:16] == 16'h0000 && v[15:0] <= MAX_MATCH_WINDOW) begin
            match_window_r <= v[15:0];
          end
        end
        OFS_ASSIGN: begin
          v = merge({20'h0, asg_out_r, asg_in_b_r, asg_in_a_r}, wdata_r, wstrb_r);
          asg_in_a_r <= v[ASG_IN_A_LSB +: 4];
          asg_in_b_r <= v[ASG_IN_B_LSB +: 4];
          asg_out_r <= v[ASG_OUT_LSB +: 4];
        end
        default: begin
          v = '0;
        end
      endcase
    end
  end

  // Restart: mode, form and polarity only change here, never mid-motion
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      restart_r <= 1'b0;
      mode_eff_r <= RST_MODE_SEL;
      form_eff_r <= RST_FORM;
      inv_eff_r <= RST_INV;
    end else begin
      restart_r <= wr_fire && awaddr_r == OFS_RESTART && wstrb_r[0] && wdata_r[0];
      if (wr_fire && awaddr_r == OFS_RESTART && wstrb_r[0] && wdata_r[0]) begin
        mode_eff_r <= mode_sel_r;
        form_eff_r <= form_r;
        inv_eff_r <= inv_r;
      end
    end
  end

  // Read channel, data registered one cycle after the address is taken
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (axil_req_i.arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= mapped(axil_req_i.araddr) ? RESP_OKAY : RESP_SLVERR;
      case (axil_req_i.araddr)
        OFS_MODE: rdata_r <= {22'h0, inv_r, 1'b0, form_r, mode_sel_r};
        OFS_CLAMP_LEVEL: rdata_r <= {16'h0, clamp_level_r};
        OFS_MATCH_WINDOW: rdata_r <= {16'h0, match_window_r};
        OFS_ASSIGN: rdata_r <= {20'h0, asg_out_r, asg_in_b_r, asg_in_a_r};
        OFS_STATUS: rdata_r <= {16'h0, mode_eff_r, 2'h0, inv_eff_r, 1'b0, form_eff_r,
                                1'b0, position_mode_o, speed_match_r, clamp_active_o};
        OFS_POS_CMD: rdata_r <= pos_cmd_r;
        OFS_CLAMP_POS: rdata_r <= clamp_pos_r;
        default: rdata_r <= '0;
      endcase
    end else if (axil_req_i.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Bus answers
  always_comb begin
    axil_rsp_o.awready = !aw_got_r && !bvalid_r;
    axil_rsp_o.wready = !w_got_r && !bvalid_r;
    axil_rsp_o.bvalid = bvalid_r;
    axil_rsp_o.bresp = bresp_r;
    axil_rsp_o.arready = !rvalid_r;
    axil_rsp_o.rvalid = rvalid_r;
    axil_rsp_o.rdata = rdata_r;
    axil_rsp_o.rresp = rresp_r;
  end

  // Three-stage pin sync; a level counts once stages two and three agree
  assign pin_raw = {term_in_i, ref_pin_b_i, ref_pin_a_i};
  for (genvar p = 0; p < NP; p++) begin : g_pin
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        sync1_r[p] <= 1'b1;
        sync2_r[p] <= 1'b1;
        sync3_r[p] <= 1'b1;
        pin_filt_r[p] <= 1'b1;
      end else begin
        sync1_r[p] <= pin_raw[p];
        sync2_r[p] <= sync1_r[p];
        sync3_r[p] <= sync2_r[p];
        if (sync2_r[p] == sync3_r[p]) begin
          pin_filt_r[p] <= sync3_r[p];
        end
      end
    end
  end

  // Polarity: bit 1 inverts the step channel, bit 0 the direction channel
  assign ch_a = pin_filt_r[0] ^ inv_eff_r[1];
  assign ch_b = pin_filt_r[1] ^ inv_eff_r[0];

  // Count per form; B leading A is forward, direction high is forward
  always_comb begin
    pos_delta = 2'sd0;
    case (form_eff_r)
      FORM_STEP_DIR: begin
        if (ch_a && !ch_a_prev_r) begin
          pos_delta = ch_b ? 2'sd1 : -2'sd1;
        end
      end
      FORM_FWD_REV: begin
        if (ch_a && !ch_a_prev_r && !(ch_b && !ch_b_prev_r)) begin
          pos_delta = 2'sd1;
        end else if (ch_b && !ch_b_prev_r && !(ch_a && !ch_a_prev_r)) begin
          pos_delta = -2'sd1;
        end
      end
      FORM_QUAD_X1: begin
        if (ch_a && !ch_a_prev_r) begin
          pos_delta = ch_b ? 2'sd1 : -2'sd1;
        end
      end
      FORM_QUAD_X2, FORM_QUAD_X4: begin
        if (ch_a != ch_a_prev_r) begin
          pos_delta = (ch_a == ch_b) ? 2'sd1 : -2'sd1;
        end else if (form_eff_r == FORM_QUAD_X4 && ch_b != ch_b_prev_r) begin
          pos_delta = (ch_b != ch_a) ? 2'sd1 : -2'sd1;
        end
      end
      default: begin
        pos_delta = 2'sd0;
      end
    endcase
  end

  // Position command; first cycle of new settings skipped so new polarity makes no edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ch_a_prev_r <= 1'b1;
      ch_b_prev_r <= 1'b1;
      pos_cmd_r <= '0;
    end else begin
      ch_a_prev_r <= ch_a;
      ch_b_prev_r <= ch_b;
      if (position_mode_o && !restart_r) begin
        pos_cmd_r <= pos_cmd_r + 32'(signed'(pos_delta));
      end
    end
  end

  assign position_mode_o = mode_eff_r == CTRL_POSITION;
  assign pos_cmd_o = pos_cmd_r;

  // Clamp request via either input assignment; unmapped index never asserts
  always_comb begin
    clamp_req = 1'b0;
    for (int t = 0; t < IN_TERMS; t++) begin
      if ((asg_in_a_r == 4'(t) || asg_in_b_r == 4'(t)) && !pin_filt_r[t+2]) begin
        clamp_req = 1'b1;
      end
    end
  end

  assign pcon_on = !pin_filt_r[PCON_TERM+2];
  assign ref_abs = speed_ref_i[15] ? 17'(-$signed({speed_ref_i[15], speed_ref_i})) : {1'b0, speed_ref_i};

  // Engage condition, level compared live so a new level acts at once
  always_comb begin
    case (mode_eff_r)
      CTRL_SPEED: clamp_cond = clamp_req && ref_abs < {1'b0, clamp_level_r};
      CTRL_SPEED_CLAMP: clamp_cond = pcon_on && ref_abs < {1'b0, clamp_level_r};
      default: clamp_cond = 1'b0;
    endcase
  end

  // Capture position on entry, hold while the condition stays true
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clamp_state_r <= CLAMP_FREE;
      clamp_pos_r <= '0;
    end else begin
      case (clamp_state_r)
        CLAMP_FREE: begin
          if (clamp_cond) begin
            clamp_state_r <= CLAMP_HOLD;
            clamp_pos_r <= feedback_pos_i;
          end
        end
        CLAMP_HOLD: begin
          if (!clamp_cond) begin
            clamp_state_r <= CLAMP_FREE;
          end
        end
        default: begin
          clamp_state_r <= CLAMP_FREE;
        end
      endcase
    end
  end

  // While held the loop sees the error, so any push is driven back
  assign clamp_active_o = clamp_state_r == CLAMP_HOLD;
  assign clamp_err = clamp_pos_r - feedback_pos_i;
  assign clamp_error_o = clamp_active_o ? clamp_err : '0;
  assign clamp_in_band_o = clamp_active_o && clamp_err >= -32'sd1 && clamp_err <= 32'sd1;
  assign speed_cmd_o = clamp_active_o ? 16'sh0000 : speed_ref_i;

  // Speed match, registered; window compared live so a new value acts at once
  assign spd_diff = 18'(motor_speed_i) - 18'(speed_ref_i);
  assign spd_diff_abs = spd_diff[17] ? 18'(-spd_diff) : 18'(spd_diff);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      speed_match_r <= 1'b0;
      positioning_complete_output_r <= 1'b0;
    end else begin
      speed_match_r <= !position_mode_o && spd_diff_abs < {2'b00, match_window_r};
      positioning_complete_output_r <= position_mode_o && position_done_i;
    end
  end

  // Output terminals, active low; the routed one carries match or positioning complete
  for (genvar o = 0; o < OUT_TERMS; o++) begin : g_out
    assign term_out_o[o] = !(asg_out_r == 4'(o) && (position_mode_o ? positioning_complete_output_r : speed_match_r));
  end
endmodule : srfe_top
`default_nettype wire

// [bench/srfe_sva.sv]
// Checker of port relations for the servo reference front end
`timescale 1ns/10ps
`default_nettype none
module srfe_sva (
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire srfe_pkg::srfe_axil_req_type axil_req_i, // Bus request
  input wire srfe_pkg::srfe_axil_rsp_type axil_rsp_o, // Bus response
  input wire logic signed [15:0] speed_ref_i, // Speed reference
  input wire logic signed [31:0] feedback_pos_i, // Encoder position
  input wire logic signed [15:0] speed_cmd_o, // Speed command
  input wire logic clamp_active_o, // Clamp engaged
  input wire logic signed [31:0] clamp_error_o, // Clamp error
  input wire logic clamp_in_band_o, // Within one pulse
  input wire logic position_mode_o, // Position control
  input wire logic signed [31:0] pos_cmd_o // Position command
);
  import srfe_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Captured position seen through the error; must not drift while clamped
  logic signed [31:0] cap_pos;
  assign cap_pos = clamp_error_o + feedback_pos_i;
  sequence s_held;
    clamp_active_o ##1 clamp_active_o;
  endsequence
  sequence s_speed_pair;
    !position_mode_o ##1 !position_mode_o;
  endsequence
  a_clamp_zero: assert property (clamp_active_o |-> speed_cmd_o == 16'h0000)
    else $error("speed command not zero while clamped");
  a_free_pass: assert property (!clamp_active_o |-> speed_cmd_o == speed_ref_i)
    else $error("speed reference not passed through");
  a_error_idle: assert property (!clamp_active_o |-> clamp_error_o == 32'h0000_0000)
    else $error("clamp error not zero while free");
  a_band_exact: assert property (clamp_in_band_o == (clamp_active_o &&
    clamp_error_o inside {32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0001}))
    else $error("in band flag disagrees with clamp error");
  a_hold_spot: assert property (s_held |-> $stable(cap_pos))
    else $error("clamp position moved while clamped");
  a_no_pos_clamp: assert property (position_mode_o |-> !clamp_active_o)
    else $error("clamp engaged in position control");
  a_count_idle: assert property (s_speed_pair |-> $stable(pos_cmd_o))
    else $error("position command moved in speed control");
  a_b_clear: assert property (axil_rsp_o.bvalid && axil_req_i.bready |=> !axil_rsp_o.bvalid)
    else $error("write response repeated");
  a_r_clear: assert property (axil_rsp_o.rvalid && axil_req_i.rready |=> !axil_rsp_o.rvalid)
    else $error("read response repeated");
  a_aw_block: assert property (axil_rsp_o.bvalid |-> !axil_rsp_o.awready && !axil_rsp_o.wready)
    else $error("write accepted while response pending");
endmodule : srfe_sva
bind srfe_top srfe_sva u_srfe_sva (.clk_i(clk_i), .resetn_i(resetn_i), .axil_req_i(axil_req_i),
  .axil_rsp_o(axil_rsp_o), .speed_ref_i(speed_ref_i), .feedback_pos_i(feedback_pos_i),
  .speed_cmd_o(speed_cmd_o), .clamp_active_o(clamp_active_o), .clamp_error_o(clamp_error_o),
  .clamp_in_band_o(clamp_in_band_o), .position_mode_o(position_mode_o), .pos_cmd_o(pos_cmd_o));
`default_nettype wire

// [bench/srfe_host_model.sv]
// Host motion controller model sending pulse-train position references
`timescale 1ns/10ps
`default_nettype none
module srfe_host_model (
  input wire logic clk_i, // Clock shared with the drive
  input wire logic go_i, // Start one burst
  input wire logic [2:0] form_i, // Pulse form
  input wire logic [1:0] inv_i, // Pin polarity, bit 1 step, bit 0 direction
  input wire logic fwd_i, // Forward when high
  input wire logic [7:0] count_i, // Pulses per burst
  output logic pin_a_o, // Step, forward pulse or phase A
  output logic pin_b_o, // Direction, reverse pulse or phase B
  output logic busy_o // Burst under way
);
  import srfe_pkg::*;
  // 52-cycle quadrature period stays under 200 kpps; other forms pulse every 26 cycles
  localparam int HALF = 13;
  logic a_r = 1'b0, b_r = 1'b0, busy_r = 1'b0;
  logic quad, on_b;
  // Lines stand still between bursts
  assign pin_a_o = a_r ^ inv_i[1];
  assign pin_b_o = b_r ^ inv_i[0];
  assign busy_o = busy_r;
  assign quad = form_i >= FORM_QUAD_X1;
  // Forward quadrature lets B lead A; reverse pulses use the second line
  assign on_b = quad ? fwd_i : (form_i == FORM_FWD_REV && !fwd_i);
  // Burst: direction settles half a period before the first edge
  always @(posedge clk_i) begin
    if (go_i && !busy_r) begin
      busy_r <= 1'b1;
      if (form_i == FORM_STEP_DIR) b_r <= fwd_i;
      repeat (HALF) @(posedge clk_i);
      for (int i = 0; i < count_i; i++) begin
        for (int k = 0; k < (quad ? 4 : 2); k++) begin
          if (on_b ^ (quad && k[0])) b_r <= ~b_r;
          else a_r <= ~a_r;
          repeat (HALF) @(posedge clk_i);
        end
      end
      busy_r <= 1'b0;
    end
  end
endmodule : srfe_host_model
`default_nettype wire

// [bench/srfe_top_test.sv]
// Self-checking testbench of the servo reference front end
`timescale 1ns/10ps
`default_nettype none
module srfe_top_test;
  import srfe_pkg::*;
  logic clk_i, resetn_i, position_done, clamp_active, in_band, pos_mode;
  logic pin_a, pin_b, h_go, h_fwd, h_busy;
  logic [2:0] h_form;
  logic [1:0] h_inv;
  logic [7:0] term_in;
  logic [3:0] term_out;
  logic signed [15:0] speed_ref, motor_speed, speed_cmd;
  logic signed [31:0] feedback_pos, clamp_error, pos_cmd;
  srfe_axil_req_type req;
  srfe_axil_rsp_type rsp;
  int n_errors = 0, checked = 0, cycles = 0;

  srfe_top u_srfe_top (.clk_i(clk_i), .resetn_i(resetn_i), .axil_req_i(req), .axil_rsp_o(rsp),
    .ref_pin_a_i(pin_a), .ref_pin_b_i(pin_b), .term_in_i(term_in), .term_out_o(term_out),
    .speed_ref_i(speed_ref), .motor_speed_i(motor_speed), .feedback_pos_i(feedback_pos),
    .position_done_i(position_done), .speed_cmd_o(speed_cmd), .clamp_active_o(clamp_active),
    .clamp_error_o(clamp_error), .clamp_in_band_o(in_band), .position_mode_o(pos_mode), .pos_cmd_o(pos_cmd));
  srfe_host_model u_srfe_host_model (.clk_i(clk_i), .go_i(h_go), .form_i(h_form), .inv_i(h_inv),
    .fwd_i(h_fwd), .count_i(8'h03), .pin_a_o(pin_a), .pin_b_o(pin_b), .busy_o(h_busy));

  // 100 ns period
  always #50 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task summarize;
    $display("checked %0d, n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Hang guard, well above the run's length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      summarize;
    end
  end

  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask : settle

  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge clk_i);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    chk(rsp.bresp, er);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    chk(rsp.rdata, e);
    chk(rsp.rresp, er);
  endtask : rchk

  task automatic restart(input logic [31:0] m);
    wr(OFS_MODE, m);
    wr(OFS_RESTART, 32'h0000_0001);
    settle;
  endtask : restart

  // One host burst; count must move by exactly e
  task automatic burst(input logic [2:0] f, input logic fw, input int e);
    logic [31:0] base;
    @(posedge clk_i);
    base = pos_cmd;
    h_form <= f;
    h_fwd <= fw;
    h_go <= 1'b1;
    @(posedge clk_i);
    h_go <= 1'b0;
    do @(posedge clk_i); while (h_busy);
    chk(pos_cmd - base, e);
  endtask : burst

  task automatic t_reset;
    rchk(OFS_MODE, 32'h0000_0000);
    rchk(OFS_CLAMP_LEVEL, 32'h0000_000A);
    rchk(OFS_MATCH_WINDOW, 32'h0000_000A);
    rchk(OFS_ASSIGN, 32'h0000_00FF);
    rchk(8'h40, 32'h0000_0000, RESP_SLVERR);
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    wr(OFS_CLAMP_LEVEL, 32'h0000_0BB8);
    wr(OFS_CLAMP_LEVEL, 32'h0000_0BB9);
    rchk(OFS_CLAMP_LEVEL, 32'h0000_0BB8);
    wr(OFS_CLAMP_LEVEL, 32'h0000_000A);
    wr(OFS_MATCH_WINDOW, 32'h0000_0065);
    rchk(OFS_MATCH_WINDOW, 32'h0000_000A);
    chk(pos_mode, 1'b0);
  endtask : t_reset

  // Ref 1000 rpm, motor speed at the window edge
  task automatic t_match;
    speed_ref <= 16'h03E8;
    motor_speed <= 16'h03F1;
    settle;
    chk(term_out[0], 1'b0);
    motor_speed <= 16'h03F2;
    settle;
    chk(term_out[0], 1'b1);
    motor_speed <= 16'h03DF;
    settle;
    chk(term_out[0], 1'b0);
    wr(OFS_MATCH_WINDOW, 32'h0000_0009);
    settle;
    chk(term_out[0], 1'b1);
    wr(OFS_MATCH_WINDOW, 32'h0000_0064);
    settle;
    chk(term_out[0], 1'b0);
    wr(OFS_ASSIGN, 32'h0000_02FF);
    settle;
    chk(term_out, 4'hB);
    wr(OFS_ASSIGN, 32'h0000_00FF);
  endtask : t_match

  // Clamp request on terminal 5, unmapped at first
  task automatic t_clamp;
    speed_ref <= 16'h0005;
    feedback_pos <= 32'h0000_0064;
    term_in <= 8'hDF;
    settle;
    chk(clamp_active, 1'b0);
    wr(OFS_ASSIGN, 32'h0000_00F5);
    settle;
    chk(clamp_active, 1'b1);
    chk(speed_cmd, 16'h0000);
    feedback_pos <= 32'h0000_0067;
    settle;
    chk(clamp_error, 32'hFFFF_FFFD);
    chk(in_band, 1'b0);
    feedback_pos <= 32'h0000_0063;
    settle;
    chk(clamp_error, 32'h0000_0001);
    chk(in_band, 1'b1);
    speed_ref <= 16'h000A;
    settle;
    chk(clamp_active, 1'b0);
    wr(OFS_CLAMP_LEVEL, 32'h0000_000B);
    settle;
    chk(clamp_active, 1'b1);
    term_in <= 8'hFF;
    settle;
    chk(clamp_active, 1'b0);
    wr(OFS_ASSIGN, 32'h0000_00FF);
    wr(OFS_CLAMP_LEVEL, 32'h0000_000A);
  endtask : t_clamp

  task automatic t_mode_a;
    restart(32'h0000_000A);
    speed_ref <= 16'h0005;
    term_in <= 8'hDF;
    settle;
    chk(clamp_active, 1'b0);
    term_in <= 8'hFB;
    settle;
    chk(clamp_active, 1'b1);
    speed_ref <= 16'h0014;
    settle;
    chk(clamp_active, 1'b0);
    term_in <= 8'hFF;
  endtask : t_mode_a

  task automatic t_pulse;
    int m;
    wr(OFS_MODE, 32'h0000_0001);
    settle;
    chk(pos_mode, 1'b0);
    restart(32'h0000_0001);
    chk(pos_mode, 1'b1);
    position_done <= 1'b1;
    settle;
    chk(term_out[0], 1'b0);
    position_done <= 1'b0;
    settle;
    chk(term_out[0], 1'b1);
    // Every form both ways; reverse last so the direction line ends low
    for (int f = 0; f < 5; f++) begin
      restart(32'h0000_0001 | (f << 4));
      m = (f == 3) ? 2 : (f == 4) ? 4 : 1;
      for (int d = 1; d >= 0; d--) begin
        burst(f[2:0], d[0], d ? 3 * m : -3 * m);
      end
    end
    restart(32'h0000_0001);
    wr(OFS_MODE, 32'h0000_0101);
    burst(3'h0, 1'b1, 3);
    // Host flips line polarity only while nothing counts
    for (int i = 1; i < 4; i++) begin
      restart(32'h0000_0000);
      h_inv <= i[1:0];
      restart(32'h0000_0001 | (i << 8));
      burst(3'h0, 1'b1, 3);
    end
  endtask : t_pulse

  initial begin
    clk_i = 1'b0;
    resetn_i = 1'b0;
    req = '0;
    term_in = 8'hFF;
    speed_ref = 16'h0000;
    motor_speed = 16'h0000;
    feedback_pos = 32'h0000_0000;
    position_done = 1'b0;
    h_go = 1'b0;
    h_form = 3'h0;
    h_inv = 2'h0;
    h_fwd = 1'b0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset;
    t_match;
    t_clamp;
    t_mode_a;
    t_pulse;
    summarize;
  end
endmodule : srfe_top_test
`default_nettype wire
